/* File: hdl/adc_link_cfg.svh */
// timing counts and field positions for the converter link
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH
`define RESULT_WIDTH      12
`define RESULT_LSB_POS    0
`define RESULT_MSB_POS    11
`define CHAN_SEL_WIDTH    2
`define PACE_RATIO        16
`define CONV_CLK_DIV      4
`define CHAN_ZERO_CODE    2'h0
`define CHAN_ONE_CODE     2'h1
`define CHAN_TWO_CODE     2'h2
`define CHAN_THREE_CODE   2'h3
`define STROBE_HOLD_LAST  3'h7
`endif

/* File: hdl/adc_link_pkg.sv */
// types shared by both ends of the converter link
package adc_link_pkg;
  typedef logic [11:0] result_t;
  typedef logic [1:0]  chan_t;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_CONV = 2'h1,
    DEV_DONE = 2'h3
  } dev_state_e;
  typedef enum logic [2:0] {
    HOST_IDLE  = 3'h0,
    HOST_START = 3'h1,
    HOST_WAIT  = 3'h3,
    HOST_READ  = 3'h2,
    HOST_TAKE  = 3'h6
  } host_state_e;
endpackage

/* File: hdl/adc_link_if.sv */
// pins between the converter and its host
`timescale 1ns/1ps
interface adc_link_if;
  logic        cs_b;
  logic        rd_b;
  logic        wr_b;
  logic        chan_sel_low_bit;
  logic        chan_sel_high_bit;
  logic        conv_clk;
  logic        busy;
  logic [11:0] result_out;
  logic        result_oe;
  modport device (
    input  cs_b, rd_b, wr_b, chan_sel_low_bit, chan_sel_high_bit, conv_clk,
    output busy, result_out, result_oe
  );
  modport host (
    output cs_b, rd_b, wr_b, chan_sel_low_bit, chan_sel_high_bit, conv_clk,
    input  busy, result_out, result_oe
  );
endinterface

/* File: hdl/adc_device_end.sv */
// converter end: strobe decode, channel latch, paced conversion, result bus
//
// Operation
// R1: cs and read low drive result out
// R2: cs and convert strobe low start conversion
// R3: starting conversion floats the data outputs
// R4: convert channel given during convert strobe
// R5: latch channel on read or convert rise
// R6: channel code 00..11 selects inputs zero..three
// R7: busy low for whole conversion
// R8: busy rises when conversion completes
// R9: busy rise re-enables result outputs
// R10: pace conversion from sixteen external clocks
// R11: result lsb on lowest data line
// R12: result is twelve bits, msb line eleven
// R13: host waits busy high, no early restart
`timescale 1ns/1ps
`include "adc_link_cfg.svh"
module adc_device_end #(
  parameter int PACE = `PACE_RATIO
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  adc_link_if.device       link,
  input  wire logic [11:0] analog_input_zero,
  input  wire logic [11:0] analog_input_one,
  input  wire logic [11:0] analog_input_two,
  input  wire logic [11:0] analog_input_three,
  output logic [1:0]       conv_channel,
  output logic             conv_done
);
  // two-flop synchronisers for every pin from the host
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       cs_b_s;
  logic       rd_b_s;
  logic       wr_b_s;
  logic [1:0] sel_s;
  logic       pace_s;
  logic       rd_b_q;
  logic       wr_b_q;
  logic       pace_q;

  always_ff @(posedge clk) begin
    pin_meta <= {link.conv_clk, link.chan_sel_high_bit, link.chan_sel_low_bit, link.wr_b, link.rd_b, link.cs_b};
    pin_sync <= pin_meta;
  end

  // bit positions follow the order in which the pins are packed above
  assign cs_b_s = pin_sync[0];
  assign rd_b_s = pin_sync[1];
  assign wr_b_s = pin_sync[2];
  assign sel_s  = pin_sync[4:3];
  assign pace_s = pin_sync[5];

  // edge history of the synchronised strobes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_b_q <= 1'b1;
      wr_b_q <= 1'b1;
      pace_q <= 1'b0;
    end else begin
      rd_b_q <= rd_b_s;
      wr_b_q <= wr_b_s;
      pace_q <= pace_s;
    end
  end

  // strobe decode
  logic start_req;
  logic read_req;
  logic rd_rise;
  logic wr_rise;
  logic pace_tick;
  assign start_req = !cs_b_s && !wr_b_s; // R2
  assign read_req  = !cs_b_s && !rd_b_s; // R1
  assign rd_rise   = rd_b_s && !rd_b_q;
  assign wr_rise   = wr_b_s && !wr_b_q;
  assign pace_tick = pace_s && !pace_q; // R10

  // channel decode to the selected analog input
  function automatic logic [11:0] pick_input(input logic [1:0] code,
                                             input logic [11:0] in0,
                                             input logic [11:0] in1,
                                             input logic [11:0] in2,
                                             input logic [11:0] in3);
    logic [11:0] v;
    v = in0;
    unique case (code)
      `CHAN_ZERO_CODE:  v = in0;
      `CHAN_ONE_CODE:   v = in1;
      `CHAN_TWO_CODE:   v = in2;
      `CHAN_THREE_CODE: v = in3;
    endcase
    return v; // R6
  endfunction

  // state, channel latch, sample, pace counter
  adc_link_pkg::dev_state_e state;
  adc_link_pkg::dev_state_e next_state;
  logic [1:0]  chan;
  logic [1:0]  chan_cap;
  logic [11:0] sample;
  logic [11:0] result;
  logic [4:0]  pace_cnt;
  logic        pace_end;
  logic [11:0] picked;

  logic [1:0]  conv_sel;
  logic        take_sample;
  logic        take_result;

  // a channel latched on this very edge is already the one to convert;
  // without the bypass the first pace tick could sample the old input
  assign conv_sel = (wr_rise || rd_rise) ? chan_cap : chan; // R5
  assign pace_end = (pace_cnt == 5'(PACE - 1));
  assign picked   = pick_input(conv_sel, analog_input_zero, analog_input_one,
                               analog_input_two, analog_input_three);

  // sample on each pace tick at count zero, hand over on the last
  assign take_sample = (state == adc_link_pkg::DEV_CONV) && pace_tick && (pace_cnt == 5'h00); // R4
  assign take_result = (state == adc_link_pkg::DEV_CONV) && pace_tick && pace_end; // R12

  // a new start enters conversion from idle or done; during a conversion it only restarts the pace count
  always_comb begin
    next_state = state;
    unique case (state)
      adc_link_pkg::DEV_IDLE: if (start_req) next_state = adc_link_pkg::DEV_CONV;
      adc_link_pkg::DEV_CONV: if (pace_tick && pace_end) next_state = adc_link_pkg::DEV_DONE; // R8
      adc_link_pkg::DEV_DONE: if (start_req) next_state = adc_link_pkg::DEV_CONV;
      default: next_state = adc_link_pkg::DEV_IDLE;
    endcase
  end

  // channel is sampled while the convert or read strobe is held, kept on its rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chan_cap <= `CHAN_ZERO_CODE;
    end else if (!cs_b_s && (!wr_b_s || !rd_b_s)) begin
      chan_cap <= sel_s; // R4
    end
  end

  // channel in use, taken over on the rise of either strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chan <= `CHAN_ZERO_CODE;
    end else if (wr_rise || rd_rise) begin
      chan <= chan_cap; // R5
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= adc_link_pkg::DEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pace counter runs over sixteen external clock ticks
  always_ff @(posedge clk) begin
    if (!rst_b || start_req) begin
      pace_cnt <= 5'h00;
    end else if (state == adc_link_pkg::DEV_CONV && pace_tick) begin
      pace_cnt <= pace_cnt + 5'h01; // R10
    end
  end

  // sample the input on each pace tick while the count is zero, hold the result once done
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample <= 12'h000;
      result <= 12'h000;
    end else begin
      if (take_sample) begin
        sample <= picked; // R4
      end
      if (take_result) begin
        result <= sample; // R12
      end
    end
  end

  // next values of the pins toward the host
  logic        next_busy;
  logic [11:0] next_result_out;
  logic        next_result_oe;
  logic        next_done;
  assign next_busy       = (next_state != adc_link_pkg::DEV_CONV); // R7 R8
  assign next_result_out = (next_state == adc_link_pkg::DEV_DONE && state != next_state) ? sample : result; // R11
  assign next_result_oe  = read_req && !start_req && next_busy; // R1 R3 R9
  assign next_done       = (state == adc_link_pkg::DEV_CONV) && (next_state == adc_link_pkg::DEV_DONE);

  // outputs: busy low in conversion, bus enabled by read once done
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.busy       <= 1'b1;
      link.result_out <= 12'h000;
      link.result_oe  <= 1'b0;
      conv_channel    <= `CHAN_ZERO_CODE;
      conv_done       <= 1'b0;
    end else begin
      link.busy       <= next_busy; // R7 R8
      link.result_out <= next_result_out; // R11
      link.result_oe  <= next_result_oe; // R1 R3 R9
      conv_channel    <= chan;
      conv_done       <= next_done;
    end
  end
endmodule

/* File: hdl/adc_host_end.sv */
// host end: converts on request, waits on busy, reads the result
`timescale 1ns/1ps
`include "adc_link_cfg.svh"
module adc_host_end #(
  parameter int CLK_DIV = `CONV_CLK_DIV
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  adc_link_if.host         link,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_chan,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [11:0]      rsp_data
);
  logic        busy_meta;
  logic        busy_s;
  logic [11:0] data_meta;
  logic [11:0] data_s;
  logic [7:0]  div_cnt;
  logic [2:0]  hold;
  adc_link_pkg::host_state_e state;

  // conversion clock divided from clk, sixteen ticks per sample
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_cnt       <= 8'h00;
      link.conv_clk <= 1'b0;
    end else if (div_cnt == 8'(CLK_DIV - 1)) begin
      div_cnt       <= 8'h00;
      link.conv_clk <= !link.conv_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // synchronise busy and the data bus
  always_ff @(posedge clk) begin
    busy_meta <= link.busy;
    busy_s    <= busy_meta;
    data_meta <= link.result_out;
    data_s    <= data_meta;
  end

  assign req_ready = (state == adc_link_pkg::HOST_IDLE) && busy_s;

  // strobe sequencer; each strobe held long enough to pass the device synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state                  <= adc_link_pkg::HOST_IDLE;
      link.cs_b              <= 1'b1;
      link.wr_b              <= 1'b1;
      link.rd_b              <= 1'b1;
      link.chan_sel_low_bit  <= 1'b0;
      link.chan_sel_high_bit <= 1'b0;
      hold                   <= 3'h0;
      rsp_valid              <= 1'b0;
      rsp_data               <= 12'h000;
    end else begin
      rsp_valid <= 1'b0;
      hold      <= hold + 3'h1;
      unique case (state)
        adc_link_pkg::HOST_IDLE: if (req_ready && req_valid) begin
          link.chan_sel_low_bit  <= req_chan[0];
          link.chan_sel_high_bit <= req_chan[1];
          link.cs_b <= 1'b0;
          link.wr_b <= 1'b0;
          hold      <= 3'h0;
          state     <= adc_link_pkg::HOST_START;
        end
        adc_link_pkg::HOST_START: if (hold == `STROBE_HOLD_LAST) begin
          link.cs_b <= 1'b1;
          link.wr_b <= 1'b1;
          hold      <= 3'h0;
          state     <= adc_link_pkg::HOST_WAIT;
        end
        adc_link_pkg::HOST_WAIT: if (hold == `STROBE_HOLD_LAST && busy_s) begin
          link.cs_b <= 1'b0;
          link.rd_b <= 1'b0;
          hold      <= 3'h0;
          state     <= adc_link_pkg::HOST_READ;
        end else if (hold == `STROBE_HOLD_LAST) begin
          hold <= `STROBE_HOLD_LAST;
        end
        adc_link_pkg::HOST_READ: if (hold == `STROBE_HOLD_LAST) begin
          rsp_data  <= data_s;
          rsp_valid <= 1'b1;
          link.cs_b <= 1'b1;
          link.rd_b <= 1'b1;
          hold      <= 3'h0;
          state     <= adc_link_pkg::HOST_TAKE;
        end
        adc_link_pkg::HOST_TAKE: if (hold == `STROBE_HOLD_LAST) begin
          state <= adc_link_pkg::HOST_IDLE;
        end
        default: state <= adc_link_pkg::HOST_IDLE;
      endcase
    end
  end
endmodule

/* File: sim/adc_link_monitor.sv */
// assertions on the pins between host end and converter end
`timescale 1ns/1ps
module adc_link_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cs_b,
  input wire logic        rd_b,
  input wire logic        wr_b,
  input wire logic        chan_sel_low_bit,
  input wire logic        chan_sel_high_bit,
  input wire logic        conv_clk,
  input wire logic        busy,
  input wire logic [11:0] result_out,
  input wire logic        result_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] ticks;
  logic       clk_q;
  // count conversion clock rises while busy is low and the start strobe is released
  always_ff @(posedge clk) begin
    clk_q <= conv_clk;
    if (!rst_b || busy || !wr_b) ticks <= 6'h0;
    else if (conv_clk && !clk_q) ticks <= ticks + 6'h1;
  end
  // start strobe and a settled read access
  sequence start_seq;
    !cs_b && $fell(wr_b);
  endsequence
  sequence read_seq;
    (!cs_b && !rd_b && busy) [*6];
  endsequence
  chk_start_busy: assert property (start_seq |-> ##[1:6] !busy)
    else $error("busy did not fall after start");
  chk_busy_holds: assert property ($fell(busy) |-> !busy [*8])
    else $error("busy rose too early");
  chk_busy_ends: assert property ($fell(busy) |-> ##[16:300] $rose(busy))
    else $error("busy did not return high");
  chk_pace_count: assert property ($rose(busy) |-> ticks inside {[15:17]})
    else $error("conversion length not sixteen clocks");
  chk_float_conv: assert property (!busy |-> !result_oe)
    else $error("result driven while converting");
  chk_read_drive: assert property (read_seq |-> result_oe)
    else $error("result not driven on read");
  chk_bus_steady: assert property (result_oe && $past(result_oe) |-> $stable(result_out))
    else $error("result changed while driven");
  chk_chan_hold: assert property (!wr_b && !$past(wr_b) |-> $stable({chan_sel_high_bit, chan_sel_low_bit}))
    else $error("channel moved during strobe");
  chk_no_early: assert property (start_seq |-> busy)
    else $error("start while busy low");
  chk_read_late: assert property ($fell(rd_b) |-> busy)
    else $error("read while busy low");
endmodule

/* File: sim/tb_top.sv */
// self-checking bench joining host end and converter end
`timescale 1ns/1ps
module tb_top;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  req_valid = 1'b0;
  adc_link_pkg::chan_t   req_chan = 2'h0;
  adc_link_pkg::chan_t   ch;
  logic                  req_ready;
  logic                  rsp_valid;
  adc_link_pkg::result_t rsp_data;
  adc_link_pkg::result_t bus_seen;
  adc_link_pkg::result_t ain [4];
  logic [1:0]            conv_channel;
  logic                  conv_done;
  logic [15:0]           done_cnt = 16'h0000;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  int                    seed = 32'hab5c38fa;
  adc_link_if link_if ();
  always #5 clk = ~clk;
  adc_host_end #(.CLK_DIV(1)) adc_host_end_inst (
    .clk(clk), .rst_b(rst_b), .link(link_if), .req_valid(req_valid), .req_chan(req_chan),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  adc_device_end #(.PACE(16)) adc_device_end_inst (
    .clk(clk), .rst_b(rst_b), .link(link_if), .analog_input_zero(ain[0]), .analog_input_one(ain[1]),
    .analog_input_two(ain[2]), .analog_input_three(ain[3]), .conv_channel(conv_channel), .conv_done(conv_done));
  adc_link_monitor adc_link_monitor_inst (
    .clk(clk), .rst_b(rst_b), .cs_b(link_if.cs_b), .rd_b(link_if.rd_b), .wr_b(link_if.wr_b),
    .chan_sel_low_bit(link_if.chan_sel_low_bit), .chan_sel_high_bit(link_if.chan_sel_high_bit),
    .conv_clk(link_if.conv_clk), .busy(link_if.busy), .result_out(link_if.result_out),
    .result_oe(link_if.result_oe));
  // last word seen on the result lines while driven
  always @(posedge clk) if (link_if.result_oe === 1'b1) bus_seen <= link_if.result_out;
  // finished conversions, counted from the completion pulse
  always @(posedge clk) if (conv_done === 1'b1) done_cnt <= done_cnt + 16'h0001;
  // expected result for a channel code
  function automatic adc_link_pkg::result_t pick(input adc_link_pkg::chan_t c);
    return ain[c];
  endfunction
  // comparisons and closing report
  task automatic cmp_word(input string nm, input adc_link_pkg::result_t e, input adc_link_pkg::result_t g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_chan(input string nm, input adc_link_pkg::chan_t e, input adc_link_pkg::chan_t g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_num(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for ready (0) or response (1)
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    while ((which ? rsp_valid : req_ready) !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n > 1000) begin
        error_cnt++;
        $display("BAD wait exp 1 got %b", which ? rsp_valid : req_ready);
        conclude();
      end
    end
  endtask
  // every channel code, rail values, then random traffic back to back
  initial begin
    for (int k = 0; k < 4; k++) ain[k] = 12'h0;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 24; i++) begin
      ch = (i < 4) ? 2'(i) : 2'($random(seed));
      for (int k = 0; k < 4; k++) ain[k] = 12'($random(seed));
      if (i < 8) ain[ch] = i[0] ? 12'hfff : 12'h000;
      wait_hi(0);
      req_chan = ch;
      req_valid = 1'b1;
      @(posedge clk) #1;
      req_valid = 1'b0;
      wait_hi(1);
      cmp_word("rsp_data", pick(ch), rsp_data);
      cmp_word("result_out", pick(ch), bus_seen);
      cmp_chan("conv_channel", ch, conv_channel);
      cmp_num("conv_done", 16'(i + 1), done_cnt);
      $display("test %0d chan %0d done", i, ch);
    end
    conclude();
  end
endmodule
